// file: rtl/rsq_map.vh
// Constants for the reset status and release sequencer.
// Assumes mclk at 20 MHz; included by bare name.
`ifndef RSQ_MAP_VH
`define RSQ_MAP_VH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define RSQ_ADDR_W            4
`define RSQ_OFF_STATUS        4'h0
`define RSQ_OFF_OSC           4'h1
`define RSQ_OFF_SEQ           4'h2
`define RSQ_STATUS_RESET      16'h0003
`define RSQ_STATUS_WMASK      16'hc1ff

// ---------------------------------------------------------------
// Status fields
// ---------------------------------------------------------------
`define RSQ_B_TRAP            15
`define RSQ_B_ILLOP           14
`define RSQ_B_REG_SB          8
`define RSQ_B_PIN             7
`define RSQ_B_INSTR           6
`define RSQ_B_WDEN            5
`define RSQ_B_WD_TMO          4
`define RSQ_B_SLEEP           3
`define RSQ_B_IDLE            2
`define RSQ_B_BOR             1
`define RSQ_B_POR             0

// ---------------------------------------------------------------
// Oscillator codes and timing
// ---------------------------------------------------------------
`define RSQ_OSC_FAST_RC       3'h0
`define RSQ_CLK_MHZ           20
`define RSQ_T_POR_US          10
`define RSQ_T_START_REG_US    20
`define RSQ_T_PUT_MS          64
`define RSQ_T_RST_US          20
`define RSQ_T_LOCK_US         20
`define RSQ_T_MON_US          100
`define RSQ_XTAL_COUNT        1024
`define RSQ_CNT_W             24

`endif

// file: rtl/rsq_timer.v
// One-shot down counter for the sequencer delays.
// Assumes load and count widths of RSQ_CNT_W.
`timescale 1ns/1ps
`default_nettype none
`include "rsq_map.vh"

module rsq_timer (
   input  wire                   mclk,
   input  wire                   rst,
   input  wire                   load,
   input  wire [`RSQ_CNT_W-1:0]  count,
   output wire                   busy
);
   reg [`RSQ_CNT_W-1:0] cnt_q;

   always @(posedge mclk) begin
      if (rst) begin
         cnt_q <= {`RSQ_CNT_W{1'b0}};
      end else if (load) begin
         cnt_q <= count;
      end else if (cnt_q != {`RSQ_CNT_W{1'b0}}) begin
         cnt_q <= cnt_q - {{(`RSQ_CNT_W-1){1'b0}}, 1'b1};
      end
   end

   assign busy = (cnt_q != {`RSQ_CNT_W{1'b0}});
endmodule

`default_nettype wire

// file: rtl/rsq_sequencer.v
// Reset status register and system reset release sequencer.
// Assumes reset sources are one-cycle pulses synchronous to mclk.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "rsq_map.vh"

// Summary of operation
// R1: Trap conflict sets bit 15; POR clears
// R2: Illegal op or pointer sets bit 14
// R3: Bits 13..9 always read zero
// R4: Bit 8 puts regulator standby in sleep
// R5: Pin clear sets bit 7; POR clears
// R6: Reset instruction sets bit 6; POR clears
// R7: Watchdog on if bit 5 or cfg
// R8: Timeout sets bit 4; power-save or POR clears
// R9: Sleep sets bit 3, idle bit 2
// R10: Brown-out sets bit 1, resets to one
// R11: Power-on sets bit 0, resets to one
// R12: Software writes flags, never causes reset
// R13: POR clears trap, illop, pin, instr, sleep, idle
// R14: Clock source chosen by reset type
// R15: POR holds power-on, startup, state delays
// R16: Startup 20us regulated else 64ms timer
// R17: Other resets hold only state time; BOR here holds the same power-on, startup and state delays as POR
// R18: Crystal start-up counts 1024 periods
// R19: Clock delays run parallel to reset
// R20: Execution waits for valid system clock
// R21: Failed clock at monitor start uses fast RC
// R22: Monitor waits 100us after reset delays with crystal or PLL source, else starts at once
// R23: System reset low while source active
module rsq_sequencer #(
   parameter [`RSQ_CNT_W-1:0] PUT_CYCLES = `RSQ_T_PUT_MS * 1000 * `RSQ_CLK_MHZ
) (
   input  wire                    mclk,
   input  wire                    rst,
   input  wire [`RSQ_ADDR_W-1:0]  reg_addr,
   input  wire [15:0]             reg_wdata,
   input  wire                    reg_wr,
   input  wire                    reg_rd,
   output reg  [15:0]             reg_rdata,
   input  wire                    por_evt,
   input  wire                    bor_evt,
   input  wire                    master_clear_pin,
   input  wire                    reset_instr,
   input  wire                    wdt_timeout,
   input  wire                    trap_conflict,
   input  wire                    illegal_op,
   input  wire                    power_save_instr,
   input  wire                    power_save_idle,
   input  wire                    wake_evt,
   input  wire                    watchdog_cfg_enable,
   input  wire                    clk_switch_en,
   input  wire                    regulator_en,
   input  wire                    clock_fail_monitor_en,
   input  wire [2:0]              initial_osc_select_cfg,
   input  wire                    src_crystal,
   input  wire                    src_pll,
   input  wire                    osc_clk_edge,
   input  wire                    pll_locked,
   input  wire                    clk_valid,
   output wire                    system_reset_n,
   output wire                    exec_enable,
   output wire                    watchdog_enable,
   output wire                    regulator_standby,
   output reg  [2:0]              current_osc_select,
   output reg                     monitor_active,
   output reg                     osc_fail_trap
);
   // ------------------------------------------------------------
   // Delay counts
   // ------------------------------------------------------------
   localparam [`RSQ_CNT_W-1:0] POR_CYC   = `RSQ_T_POR_US * `RSQ_CLK_MHZ;
   localparam [`RSQ_CNT_W-1:0] STREG_CYC = `RSQ_T_START_REG_US * `RSQ_CLK_MHZ;
   localparam [`RSQ_CNT_W-1:0] RST_CYC   = `RSQ_T_RST_US * `RSQ_CLK_MHZ;
   localparam [`RSQ_CNT_W-1:0] LOCK_CYC  = `RSQ_T_LOCK_US * `RSQ_CLK_MHZ;
   localparam [`RSQ_CNT_W-1:0] MDLY_CYC  = `RSQ_T_MON_US * `RSQ_CLK_MHZ;
   localparam [10:0]           XTAL_MAX  = `RSQ_XTAL_COUNT;

   localparam [3:0] S_RUN  = 4'b0001;
   localparam [3:0] S_HOLD = 4'b0010;
   localparam [3:0] S_MDLY = 4'b0100;
   localparam [3:0] S_MON  = 4'b1000;

   reg  [15:0]            stat_q;
   reg  [15:0]            stat_d;
   reg  [3:0]             state_q;
   reg  [3:0]             state_d;
   reg  [2:0]             osc_ctl_q;
   reg  [10:0]            xtal_q;
   reg                    lock_wait_q;
   reg                    sleep_q;
   wire                   power_event;
   wire                   short_event;
   wire                   any_src;
   wire                   hold_load;
   wire                   lock_load;
   wire                   mdly_load;
   wire                   hold_busy;
   wire                   lock_busy;
   wire                   mdly_busy;
   wire                   clk_ready;
   wire [`RSQ_CNT_W-1:0]  startup_cyc;
   wire [`RSQ_CNT_W-1:0]  hold_cyc;

   assign power_event = por_evt | bor_evt;
   assign short_event = master_clear_pin | reset_instr | wdt_timeout
                      | trap_conflict | illegal_op;
   assign any_src     = power_event | short_event;
   assign startup_cyc = regulator_en ? STREG_CYC : PUT_CYCLES;              // see R16
   assign hold_cyc    = power_event ? (POR_CYC + startup_cyc + RST_CYC)     // see R15
                      : (wake_evt && sleep_q) ? startup_cyc                 // see R16
                      : RST_CYC;                                            // see R17
   assign hold_load   = any_src | (wake_evt & sleep_q & regulator_en);

   // ------------------------------------------------------------
   // Status register
   // ------------------------------------------------------------
   always @* begin
      stat_d = stat_q;
      if (reg_wr && reg_addr == `RSQ_OFF_STATUS) begin
         stat_d = reg_wdata & `RSQ_STATUS_WMASK;                            // see R12
      end
      if (power_save_instr || power_save_idle) begin
         stat_d[`RSQ_B_WD_TMO] = 1'b0;                                      // see R8
      end
      if (por_evt) begin
         stat_d[`RSQ_B_TRAP]  = 1'b0;                                       // see R13
         stat_d[`RSQ_B_ILLOP] = 1'b0;
         stat_d[`RSQ_B_PIN]   = 1'b0;
         stat_d[`RSQ_B_INSTR] = 1'b0;
         stat_d[`RSQ_B_WD_TMO] = 1'b0;
         stat_d[`RSQ_B_SLEEP] = 1'b0;                                       // see R9
         stat_d[`RSQ_B_IDLE]  = 1'b0;
      end
      if (trap_conflict) stat_d[`RSQ_B_TRAP] = 1'b1;                        // see R1
      if (illegal_op)    stat_d[`RSQ_B_ILLOP] = 1'b1;                       // see R2
      if (master_clear_pin) stat_d[`RSQ_B_PIN] = 1'b1;                      // see R5
      if (reset_instr)   stat_d[`RSQ_B_INSTR] = 1'b1;                       // see R6
      if (wdt_timeout)   stat_d[`RSQ_B_WD_TMO] = 1'b1;                      // see R8
      if (power_save_instr) stat_d[`RSQ_B_SLEEP] = 1'b1;                    // see R9
      if (power_save_idle)  stat_d[`RSQ_B_IDLE] = 1'b1;
      if (bor_evt)       stat_d[`RSQ_B_BOR] = 1'b1;                         // see R10
      if (por_evt)       stat_d[`RSQ_B_POR] = 1'b1;                         // see R11
      stat_d[13:9] = 5'h00;                                                 // see R3
   end

   always @(posedge mclk) begin
      if (rst) begin
         stat_q <= `RSQ_STATUS_RESET;                                       // see R10 R11
      end else begin
         stat_q <= stat_d;
      end
   end

   assign watchdog_enable   = stat_q[`RSQ_B_WDEN] | watchdog_cfg_enable;    // see R7
   assign regulator_standby = sleep_q & stat_q[`RSQ_B_REG_SB];              // see R4

   always @(posedge mclk) begin
      if (rst) begin
         sleep_q <= 1'b0;
      end else if (power_save_instr) begin
         sleep_q <= 1'b1;
      end else if (wake_evt || any_src) begin
         sleep_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Clock source selection
   // ------------------------------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         osc_ctl_q <= `RSQ_OSC_FAST_RC;
      end else if (monitor_active && !clk_valid && clock_fail_monitor_en) begin
         osc_ctl_q <= `RSQ_OSC_FAST_RC;                                     // see R21
      end else if (power_event || !clk_switch_en) begin
         osc_ctl_q <= initial_osc_select_cfg;                               // see R14
      end else if (reg_wr && reg_addr == `RSQ_OFF_OSC) begin
         osc_ctl_q <= reg_wdata[14:12];
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         current_osc_select <= `RSQ_OSC_FAST_RC;
      end else begin
         current_osc_select <= osc_ctl_q;
      end
   end

   // ------------------------------------------------------------
   // Oscillator start-up and lock, parallel to reset hold
   // ------------------------------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         xtal_q <= 11'h000;
      end else if (power_event) begin
         xtal_q <= src_crystal ? XTAL_MAX : 11'h000;                        // see R18 R19
      end else if (xtal_q != 11'h000 && osc_clk_edge) begin
         xtal_q <= xtal_q - 11'h001;
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         lock_wait_q <= 1'b0;
      end else if (power_event) begin
         lock_wait_q <= src_pll;
      end else if (lock_wait_q && xtal_q == 11'h000 && !lock_busy && pll_locked) begin
         lock_wait_q <= 1'b0;
      end
   end

   assign lock_load = power_event & src_pll;
   assign clk_ready = (xtal_q == 11'h000) & !lock_wait_q;
   assign exec_enable = system_reset_n & clk_ready;                         // see R20

   // ------------------------------------------------------------
   // Reset hold and monitor delay
   // ------------------------------------------------------------
   always @* begin
      state_d = state_q;
      case (state_q)
         S_RUN: begin
            if (hold_load) state_d = S_HOLD;
         end
         S_HOLD: begin
            if (!hold_busy && !any_src) begin
               state_d = (src_crystal | src_pll) ? S_MDLY : S_MON;          // see R22
            end
         end
         S_MDLY: begin
            if (hold_load) state_d = S_HOLD;
            else if (!mdly_busy) state_d = S_MON;
         end
         S_MON: begin
            if (hold_load) state_d = S_HOLD;
         end
         default: state_d = S_HOLD;
      endcase
   end

   always @(posedge mclk) begin
      if (rst) begin
         state_q <= S_HOLD;
      end else begin
         state_q <= state_d;
      end
   end

   assign mdly_load = (state_q == S_HOLD) && (state_d == S_MDLY);
   assign system_reset_n = !(any_src || state_q == S_HOLD);                 // see R23

   always @(posedge mclk) begin
      if (rst) begin
         monitor_active <= 1'b0;
         osc_fail_trap  <= 1'b0;
      end else begin
         monitor_active <= clock_fail_monitor_en && state_d == S_MON;
         osc_fail_trap  <= monitor_active && clock_fail_monitor_en && !clk_valid; // see R21
      end
   end

   rsq_timer u_hold (
      .mclk  (mclk),
      .rst   (rst),
      .load  (hold_load),
      .count (hold_cyc),
      .busy  (hold_busy)
   );

   rsq_timer u_lock (
      .mclk  (mclk),
      .rst   (rst),
      .load  (lock_load),
      .count (LOCK_CYC),
      .busy  (lock_busy)
   );

   rsq_timer u_mdly (
      .mclk  (mclk),
      .rst   (rst),
      .load  (mdly_load),
      .count (MDLY_CYC),
      .busy  (mdly_busy)
   );

   // ------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `RSQ_OFF_STATUS: reg_rdata <= stat_q;
            `RSQ_OFF_OSC:    reg_rdata <= {1'b0, current_osc_select, 12'h000};
            `RSQ_OFF_SEQ:    reg_rdata <= {10'h000, osc_fail_trap, monitor_active,
                                           state_q};
            default:         reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end
endmodule

`default_nettype wire

// file: tb/rsq_osc_model.sv
// Far-side model: crystal oscillator edges and PLL lock.
// Assumes one oscillator period per two mclk cycles.
`timescale 1ns/1ps
`default_nettype none
module rsq_osc_model #(
   parameter int LOCK_CYCLES = 400
) (
   input  wire logic mclk,
   input  wire logic rst,
   output var  logic osc_clk_edge,
   output var  logic pll_locked
);
   int lock_cnt;
   always @(posedge mclk) begin
      if (rst) begin
         osc_clk_edge <= 1'b0;
         pll_locked   <= 1'b0;
         lock_cnt     <= 0;
      end else begin
         osc_clk_edge <= ~osc_clk_edge;
         if (lock_cnt < LOCK_CYCLES) lock_cnt <= lock_cnt + 1;
         pll_locked <= (lock_cnt >= LOCK_CYCLES);
      end
   end
endmodule
`default_nettype wire

// file: tb/rsq_seq_properties.sv
// Port checker for the reset status and release sequencer.
// Assumes one mclk domain with synchronous reset rst.
`timescale 1ns/1ps
`default_nettype none
`include "rsq_map.vh"
module rsq_seq_props (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [3:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        por_evt,
   input wire logic        bor_evt,
   input wire logic        master_clear_pin,
   input wire logic        reset_instr,
   input wire logic        wdt_timeout,
   input wire logic        trap_conflict,
   input wire logic        illegal_op,
   input wire logic        power_save_instr,
   input wire logic        power_save_idle,
   input wire logic        watchdog_cfg_enable,
   input wire logic        watchdog_enable,
   input wire logic        system_reset_n,
   input wire logic        exec_enable
);
   // ---
   // Helpers
   // ---
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire fl_set = trap_conflict | illegal_op | master_clear_pin | reset_instr
                 | wdt_timeout | power_save_instr | power_save_idle;
   wire any_src = trap_conflict | illegal_op | master_clear_pin | reset_instr
                  | wdt_timeout | por_evt | bor_evt;
   sequence quiet_rd;
      reg_rd && !reg_wr && reg_addr == `RSQ_OFF_STATUS && !por_evt
         && !power_save_instr && !power_save_idle;
   endsequence
   property flag_p(ev, int b);
      ev ##1 quiet_rd |=> reg_rdata[b];
   endproperty
   // ---
   // Assertions
   // ---
   trap_flag_a: assert property (flag_p(trap_conflict, 15))
      else $error("trap flag not set");
   illop_flag_a: assert property (flag_p(illegal_op, 14))
      else $error("illegal op flag not set");
   rsv_zero_a: assert property (reg_rd |=> reg_rdata[13:9] == 5'h00)
      else $error("reserved bits not zero");
   pin_flag_a: assert property (flag_p(master_clear_pin, 7))
      else $error("pin clear flag not set");
   instr_flag_a: assert property (flag_p(reset_instr, 6))
      else $error("instruction reset flag not set");
   wdt_force_a: assert property (watchdog_cfg_enable |-> watchdog_enable)
      else $error("watchdog not forced on");
   tmo_flag_a: assert property (flag_p(wdt_timeout, 4))
      else $error("timeout flag not set");
   sleep_flag_a: assert property (flag_p(power_save_instr, 3))
      else $error("sleep flag not set");
   bor_flag_a: assert property (flag_p(bor_evt, 1))
      else $error("brown-out flag not set");
   por_clear_a: assert property (por_evt && !fl_set && !reg_wr ##1 quiet_rd |=>
      (reg_rdata & 16'hc0dc) == 16'h0000 && reg_rdata[0])
      else $error("power-on did not clear flags");
   short_hold_a: assert property (master_clear_pin |-> ##300 !system_reset_n)
      else $error("short reset released early");
   exec_gate_a: assert property (exec_enable |-> system_reset_n)
      else $error("execution during system reset");
   src_reset_a: assert property (any_src |-> !system_reset_n)
      else $error("source active without system reset");
endmodule
bind rsq_sequencer rsq_seq_props u_rsq_seq_props (.*);
`default_nettype wire

// file: tb/rsq_sequencer_tb.sv
// Self-checking bench for the reset status and release sequencer.
// Assumes rsq_sequencer, rsq_osc_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "rsq_map.vh"
module rsq_sequencer_tb;
   logic        mclk, rst, reg_wr, reg_rd, wd_cfg, sw_en, reg_en, pll, cvalid;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata, rdat;
   logic [8:0]  ev;
   wire  [15:0] reg_rdata;
   wire  [2:0]  cur_osc;
   wire         osc_edge, locked, sys_rst_n, exec_en, wd_en, mon_act, fail_trap, reg_sb;
   int          fail_count = 0;
   int          check_count = 0;
   rsq_osc_model u_rsq_osc_model (.mclk(mclk), .rst(rst), .osc_clk_edge(osc_edge),
      .pll_locked(locked));
   rsq_sequencer #(.PUT_CYCLES(24'd100)) u_rsq_sequencer (
      .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .por_evt(ev[0]), .master_clear_pin(ev[1]), .reset_instr(ev[2]),
      .wdt_timeout(ev[3]), .trap_conflict(ev[4]), .illegal_op(ev[5]), .bor_evt(ev[6]),
      .power_save_instr(ev[7]), .power_save_idle(ev[8]), .wake_evt(1'b0),
      .watchdog_cfg_enable(wd_cfg), .clk_switch_en(sw_en), .regulator_en(reg_en),
      .clock_fail_monitor_en(1'b1), .initial_osc_select_cfg(3'h3),
      .src_crystal(1'b1), .src_pll(pll), .osc_clk_edge(osc_edge), .pll_locked(locked),
      .clk_valid(cvalid), .system_reset_n(sys_rst_n), .exec_enable(exec_en),
      .watchdog_enable(wd_en), .regulator_standby(reg_sb), .current_osc_select(cur_osc),
      .monitor_active(mon_act), .osc_fail_trap(fail_trap));
   // ---
   // Bus and check tasks
   // ---
   task automatic chk(input string nm, input logic [15:0] exp, got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 rdat = reg_rdata;
   endtask
   task automatic pulse(input int i);
      @(posedge mclk);
      ev[i] <= 1'b1;
      @(posedge mclk);
      ev <= 9'h000;
   endtask
   // Counts hold cycles until system reset lifts
   task automatic rel(input int lo, hi);
      int n;
      n = 0;
      while (sys_rst_n !== 1'b1 && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      chk("hold", 16'h0001, 16'(n >= lo && n <= hi));
   endtask
   // ---
   // Scenarios
   // ---
   task automatic t_por;
      for (int r = 0; r < 2; r++) begin
         reg_en <= r[0];
         pulse(0);
         rel(690 + 300 * r, 710 + 300 * r);
         rd(`RSQ_OFF_STATUS);
         chk("status", 16'h0003, rdat);
      end
   endtask
   task automatic t_src;
      int bitn [1:6] = '{7, 6, 4, 15, 14, 1};
      for (int i = 1; i < 7; i++) begin
         wr(`RSQ_OFF_STATUS, 16'h0000);
         pulse(i);
         if (i == 6) rel(390, 1010);
         else rel(390, 410);
         rd(`RSQ_OFF_STATUS);
         chk("flag", 16'h0001 << bitn[i], rdat);
      end
   endtask
   task automatic t_sw;
      wr(`RSQ_OFF_STATUS, 16'hffff);
      repeat (3) @(posedge mclk);
      #1 chk("system_reset_n", 16'h0001, {15'h0, sys_rst_n});
      chk("wden", 16'h0001, {15'h0, wd_en});
      rd(`RSQ_OFF_STATUS);
      chk("status", 16'hc1ff, rdat);
      wr(`RSQ_OFF_STATUS, 16'h0000);
      #1 chk("wden", 16'h0000, {15'h0, wd_en});
      @(posedge mclk);
      wd_cfg <= 1'b1;
      #1 chk("wden", 16'h0001, {15'h0, wd_en});
      @(posedge mclk);
      wd_cfg <= 1'b0;
   endtask
   task automatic t_pwr;
      for (int i = 7; i < 9; i++) begin
         wr(`RSQ_OFF_STATUS, 16'h0010);
         pulse(i);
         rd(`RSQ_OFF_STATUS);
         chk("psave", (i == 7) ? 16'h0008 : 16'h0004, rdat);
         if (i == 7) begin
            #1 chk("standby", 16'h0000, {15'h0, reg_sb});
            wr(`RSQ_OFF_STATUS, 16'h0100);
            #1 chk("standby", 16'h0001, {15'h0, reg_sb});
         end
      end
   endtask
   task automatic t_porclr;
      wr(`RSQ_OFF_STATUS, 16'hc0dc);
      pulse(0);
      rel(990, 1010);
      rd(`RSQ_OFF_STATUS);
      chk("porclr", 16'h0001, rdat);
   endtask
   task automatic t_osc;
      sw_en <= 1'b1;
      wr(`RSQ_OFF_OSC, 16'h5000);
      pulse(1);
      rel(390, 410);
      chk("osc", 16'h0005, {13'h0, cur_osc});
      pulse(0);
      rel(990, 1010);
      chk("osc", 16'h0003, {13'h0, cur_osc});
      sw_en <= 1'b0;
      wr(`RSQ_OFF_OSC, 16'h5000);
      pulse(1);
      rel(390, 410);
      chk("osc", 16'h0003, {13'h0, cur_osc});
   endtask
   task automatic t_mon(input logic v);
      cvalid <= v;
      pll    <= ~v;
      pulse(0);
      rel(990, 1010);
      repeat (1980) @(posedge mclk);
      #1 chk("mon", 16'h0000, {15'h0, mon_act});
      repeat (40) @(posedge mclk);
      #1 chk("mon", 16'h0001, {15'h0, mon_act});
      chk("trap", {15'h0, ~v}, {15'h0, fail_trap});
      if (v) chk("exec", 16'h0001, {15'h0, exec_en});
      else chk("fastrc", {13'h0, `RSQ_OSC_FAST_RC}, {13'h0, cur_osc});
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ---
   // Clock, sequence and watchdog
   // ---
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      {rst, reg_wr, reg_rd, wd_cfg, sw_en, reg_en, pll, cvalid} = 8'h81;
      reg_addr  = 4'h0;
      reg_wdata = 16'h0000;
      ev        = 9'h000;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      t_por();
      t_src();
      t_sw();
      t_pwr();
      t_porclr();
      t_osc();
      t_mon(1'b1);
      t_mon(1'b0);
      complete_run();
   end
   initial begin
      repeat (40000) @(posedge mclk);
      fail_count++;
      complete_run();
   end
endmodule
`default_nettype wire
